// ### src/crf_core.sv
/*
  Programmer-visible register set and status flag logic of an 8-bit
  core: accumulator, two index registers, stack pointer with page
  select, program counter and status flags.
  Assumes a sequencer that issues one operation per OP_VALID_IN pulse,
  waits for BUSY_OUT low, and supplies memory data on MEM_DATA_IN.
*/
`timescale 1ns/1ps
`include "crf_regs.svh"

// Operation
// - Eight-bit accumulator carries most transfers and arithmetic.
// - Two 8-bit index registers; indexed address is operand plus index.
// - Memop mode off: arithmetic on accumulator and memory, result to A.
// - Memop mode on: first location via first index, result stored there.
// - Stack address low byte comes from the stack pointer.
// - Stack page bit 0 selects page zero, 1 selects page one.
// - Calls push return address; interrupts push it and status.
// - Sixteen-bit program counter of high and low byte registers.
// - Reset sets interrupt disable; software initialises memop, decimal.
// - Carry takes arithmetic carry or borrow, and shift results.
// - Zero flag set when result is zero, cleared otherwise.
// - Interrupt disable blocks all interrupts except software break.
// - Accepted interrupt sets interrupt disable automatically.
// - Decimal flag makes add and subtract decimal corrected.
// - Zero, overflow, negative not valid in decimal mode.
// - Live break flag reads 0; copies pushed by break and by status push have it 1.
// - Overflow set when signed byte result leaves -128..+127.
// - Negative flag set when result is negative.
// - Bit test copies bit 6 to overflow, bit 7 to negative.
// - Set and clear ops for C, I, D, T; clear only for V.
// - Push and pop of accumulator and status register.
// - Reject fast-set and slow ops; accept product, quotient, wait, halt.
// - Stack page bit lives in the mode register at 003b hex.
module crf_core (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic OP_VALID_IN,
  input wire logic [4:0] OP_IN,
  input wire logic [1:0] REG_SEL_IN,
  input wire logic [7:0] MEM_DATA_IN,
  input wire logic [15:0] OPERAND_IN,
  input wire logic IDX_SEL_IN,
  input wire logic IRQ_REQ_IN,
  input wire logic SFR_WR_IN,
  input wire logic [15:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_DATA_IN,
  output logic [7:0] ACC_OUT,
  output logic [7:0] IDX1_OUT,
  output logic [7:0] IDX2_OUT,
  output logic [7:0] SP_OUT,
  output logic [15:0] PC_OUT,
  output logic [7:0] PS_OUT,
  output logic [15:0] ADDR_OUT,
  output logic [7:0] WDATA_OUT,
  output logic WR_OUT,
  output logic MEMOP_WR_OUT,
  output logic [15:0] EA_OUT,
  output logic BUSY_OUT,
  output logic ILLEGAL_OUT,
  output logic IRQ_ACK_OUT,
  output logic WAIT_OUT,
  output logic HALT_OUT
);

  logic [7:0] acc_q;
  logic [7:0] idx1_q;
  logic [7:0] idx2_q;
  logic [7:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] ps_q;
  logic sps_q;
  crf_pkg::crf_state_t st_q;
  logic [7:0] push_ps_q;
  logic push_st_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic memop_wr_q;
  logic [15:0] ea_q;
  logic illegal_q;
  logic irq_ack_q;
  logic wait_q;
  logic halt_q;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic t_mode;
  logic [7:0] lhs;
  logic [7:0] rhs;
  logic [8:0] bin_sum;
  logic [7:0] res;
  logic carry;
  logic ovf;
  logic [4:0] lo_nib;
  logic [4:0] hi_nib;
  logic lo_adj;
  logic [15:0] stack_addr;
  logic is_sub;
  logic take_irq;

  assign t_mode = ps_q[`CRF_PS_T];
  // Memop mode takes first operand from memory at first index
  assign lhs = t_mode ? MEM_DATA_IN : acc_q;
  assign is_sub = (OP_IN == `CRF_OP_SBC);
  assign rhs = is_sub ? ~OPERAND_IN[7:0] : OPERAND_IN[7:0];
  // High stack byte from page bit, low from pointer
  assign stack_addr = {(sps_q ? `CRF_PAGE1_HI : `CRF_PAGE0_HI), sp_q};
  // Break bypasses interrupt disable
  assign take_irq = ~ps_q[`CRF_PS_I] & IRQ_REQ_IN;

  always_comb begin
    bin_sum = {1'b0, lhs} + {1'b0, rhs} + {8'h00, ps_q[`CRF_PS_C]};
    res = bin_sum[7:0];
    carry = bin_sum[8];
    ovf = (lhs[7] == rhs[7]) && (res[7] != lhs[7]);
    lo_nib = 5'h00;
    hi_nib = 5'h00;
    lo_adj = 1'b0;
    if (ps_q[`CRF_PS_D]) begin
      if (!is_sub) begin
        lo_nib = {1'b0, lhs[3:0]} + {1'b0, OPERAND_IN[3:0]} +
                 {4'h0, ps_q[`CRF_PS_C]};
        lo_adj = lo_nib > 5'h09;
        if (lo_adj) begin
          lo_nib = lo_nib + 5'h06;
        end
        hi_nib = {1'b0, lhs[7:4]} + {1'b0, OPERAND_IN[7:4]} +
                 {4'h0, lo_adj};
        if (hi_nib > 5'h09) begin
          hi_nib = hi_nib + 5'h06;
        end
        res = {hi_nib[3:0], lo_nib[3:0]};
        carry = hi_nib[4];
      end else begin
        lo_nib = {1'b0, lhs[3:0]} - {1'b0, OPERAND_IN[3:0]} -
                 {4'h0, ~ps_q[`CRF_PS_C]};
        lo_adj = lo_nib[4];
        if (lo_adj) begin
          lo_nib = lo_nib - 5'h06;
        end
        hi_nib = {1'b0, lhs[7:4]} - {1'b0, OPERAND_IN[7:4]} -
                 {4'h0, lo_adj};
        carry = ~hi_nib[4];
        if (hi_nib[4]) begin
          hi_nib = hi_nib - 5'h06;
        end
        res = {hi_nib[3:0], lo_nib[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer for multi-byte pushes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_q <= crf_pkg::CRF_ST_IDLE;
    end else begin
      case (st_q)
        crf_pkg::CRF_ST_IDLE: begin
          if (OP_VALID_IN && (OP_IN == `CRF_OP_CALL ||
              (OP_IN == `CRF_OP_IRQ && take_irq) ||
              OP_IN == `CRF_OP_BRK)) begin
            st_q <= crf_pkg::CRF_ST_PUSH2;
          end
        end
        crf_pkg::CRF_ST_PUSH2: begin
          st_q <= push_st_q ? crf_pkg::CRF_ST_PUSH3
                            : crf_pkg::CRF_ST_DONE;
        end
        crf_pkg::CRF_ST_PUSH3: st_q <= crf_pkg::CRF_ST_DONE;
        crf_pkg::CRF_ST_DONE: st_q <= crf_pkg::CRF_ST_IDLE;
        default: st_q <= crf_pkg::CRF_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stack page bit in the mode register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sps_q <= 1'b0;
    end else if (SFR_WR_IN && SFR_ADDR_IN == `CRF_CPU_MODE_ADDR) begin
      sps_q <= SFR_DATA_IN[`CRF_SPS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      acc_q <= 8'h00;
      idx1_q <= 8'h00;
      idx2_q <= 8'h00;
    end else if (OP_VALID_IN && st_q == crf_pkg::CRF_ST_IDLE) begin
      case (OP_IN)
        `CRF_OP_LOAD: begin
          case (REG_SEL_IN)
            2'b00: acc_q <= MEM_DATA_IN;
            2'b01: idx1_q <= MEM_DATA_IN;
            2'b10: idx2_q <= MEM_DATA_IN;
            default: acc_q <= acc_q;
          endcase
        end
        `CRF_OP_ADC, `CRF_OP_SBC: begin
          if (!t_mode) begin
            acc_q <= res;
          end
        end
        `CRF_OP_SHIFT: begin
          if (!t_mode) begin
            acc_q <= {acc_q[6:0], ps_q[`CRF_PS_C]};
          end
        end
        `CRF_OP_POP_A: acc_q <= MEM_DATA_IN;
        default: acc_q <= acc_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer, program counter and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sp_q <= `CRF_SP_RESET;
      pc_q <= `CRF_PC_RESET;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      memop_wr_q <= 1'b0;
      ea_q <= 16'h0000;
      push_ps_q <= 8'h00;
      push_st_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      memop_wr_q <= 1'b0;
      case (st_q)
        crf_pkg::CRF_ST_PUSH2: begin
          addr_q <= stack_addr;
          wdata_q <= pc_q[7:0];
          wr_q <= 1'b1;
          sp_q <= sp_q - 8'h01;
        end
        crf_pkg::CRF_ST_PUSH3: begin
          addr_q <= stack_addr;
          wdata_q <= push_ps_q;
          wr_q <= 1'b1;
          sp_q <= sp_q - 8'h01;
        end
        crf_pkg::CRF_ST_DONE: push_st_q <= 1'b0;
        default: begin
          if (OP_VALID_IN) begin
            case (OP_IN)
              `CRF_OP_INDEX: begin
                // Operand plus selected index
                ea_q <= OPERAND_IN +
                        {8'h00, IDX_SEL_IN ? idx2_q : idx1_q};
              end
              `CRF_OP_ADC, `CRF_OP_SBC, `CRF_OP_SHIFT: begin
                if (t_mode) begin
                  addr_q <= {8'h00, idx1_q};
                  wdata_q <= (OP_IN == `CRF_OP_SHIFT) ?
                             {MEM_DATA_IN[6:0], ps_q[`CRF_PS_C]} : res;
                  wr_q <= 1'b1;
                  memop_wr_q <= 1'b1;
                end
              end
              `CRF_OP_PUSH_A, `CRF_OP_PUSH_PS: begin
                addr_q <= stack_addr;
                wdata_q <= (OP_IN == `CRF_OP_PUSH_A) ? acc_q
                           : (ps_q | 8'h10);
                wr_q <= 1'b1;
                sp_q <= sp_q - 8'h01;
              end
              `CRF_OP_POP_A, `CRF_OP_POP_PS: begin
                addr_q <= {stack_addr[15:8], sp_q + 8'h01};
                sp_q <= sp_q + 8'h01;
              end
              `CRF_OP_CALL, `CRF_OP_IRQ, `CRF_OP_BRK: begin
                if (OP_IN != `CRF_OP_IRQ || take_irq) begin
                  addr_q <= stack_addr;
                  wdata_q <= pc_q[15:8];
                  wr_q <= 1'b1;
                  sp_q <= sp_q - 8'h01;
                  push_st_q <= (OP_IN != `CRF_OP_CALL);
                  // Break copy carries the break bit, interrupt copy clears it
                  push_ps_q <= (OP_IN == `CRF_OP_CALL) ? 8'h00 :
                               (OP_IN == `CRF_OP_BRK) ? (ps_q | 8'h10)
                               : (ps_q & 8'hef);
                end
              end
              `CRF_OP_PC_LOAD: pc_q <= OPERAND_IN;
              `CRF_OP_PC_INC: pc_q <= pc_q + 16'h0001;
              default: sp_q <= sp_q;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ps_q <= `CRF_PS_RESET;
    end else if (OP_VALID_IN && st_q == crf_pkg::CRF_ST_IDLE) begin
      case (OP_IN)
        `CRF_OP_LOAD, `CRF_OP_POP_A: begin
          ps_q[`CRF_PS_Z] <= (MEM_DATA_IN == 8'h00);
          ps_q[`CRF_PS_N] <= MEM_DATA_IN[7];
        end
        `CRF_OP_ADC, `CRF_OP_SBC: begin
          ps_q[`CRF_PS_C] <= carry;
          // Flags still written in decimal mode but meaningless there
          ps_q[`CRF_PS_Z] <= (res == 8'h00);
          ps_q[`CRF_PS_V] <= ovf;
          ps_q[`CRF_PS_N] <= res[7];
        end
        `CRF_OP_SHIFT: begin
          ps_q[`CRF_PS_C] <= lhs[7];
          ps_q[`CRF_PS_Z] <= ({lhs[6:0], ps_q[`CRF_PS_C]} == 8'h00);
          ps_q[`CRF_PS_N] <= lhs[6];
        end
        `CRF_OP_BIT: begin
          ps_q[`CRF_PS_V] <= MEM_DATA_IN[6];
          ps_q[`CRF_PS_N] <= MEM_DATA_IN[7];
          ps_q[`CRF_PS_Z] <= ((acc_q & MEM_DATA_IN) == 8'h00);
        end
        `CRF_OP_POP_PS: ps_q <= MEM_DATA_IN & 8'hef;
        `CRF_OP_SEC: ps_q[`CRF_PS_C] <= 1'b1;
        `CRF_OP_CLC: ps_q[`CRF_PS_C] <= 1'b0;
        `CRF_OP_SEI: ps_q[`CRF_PS_I] <= 1'b1;
        `CRF_OP_CLI: ps_q[`CRF_PS_I] <= 1'b0;
        `CRF_OP_SED: ps_q[`CRF_PS_D] <= 1'b1;
        `CRF_OP_CLD: ps_q[`CRF_PS_D] <= 1'b0;
        `CRF_OP_SET: ps_q[`CRF_PS_T] <= 1'b1;
        `CRF_OP_CLT: ps_q[`CRF_PS_T] <= 1'b0;
        `CRF_OP_CLV: ps_q[`CRF_PS_V] <= 1'b0;
        `CRF_OP_IRQ: begin
          if (take_irq) begin
            ps_q[`CRF_PS_I] <= 1'b1;
          end
        end
        `CRF_OP_BRK: ps_q[`CRF_PS_I] <= 1'b1;
        default: ps_q <= ps_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Instruction acceptance and low-power ops
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      illegal_q <= 1'b0;
      irq_ack_q <= 1'b0;
      wait_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      illegal_q <= OP_VALID_IN && st_q == crf_pkg::CRF_ST_IDLE &&
                   (OP_IN == `CRF_OP_FAST_SET ||
                    OP_IN == `CRF_OP_SLOW);
      irq_ack_q <= OP_VALID_IN && st_q == crf_pkg::CRF_ST_IDLE &&
                   ((OP_IN == `CRF_OP_IRQ && take_irq) ||
                    OP_IN == `CRF_OP_BRK);
      if (OP_VALID_IN && OP_IN == `CRF_OP_WAIT) begin
        wait_q <= 1'b1;
      end else if (IRQ_REQ_IN) begin
        wait_q <= 1'b0;
      end
      if (OP_VALID_IN && OP_IN == `CRF_OP_HALT_OSC) begin
        halt_q <= 1'b1;
      end else if (IRQ_REQ_IN) begin
        halt_q <= 1'b0;
      end
    end
  end

  assign ACC_OUT = acc_q;
  assign IDX1_OUT = idx1_q;
  assign IDX2_OUT = idx2_q;
  assign SP_OUT = sp_q;
  assign PC_OUT = pc_q;
  assign PS_OUT = ps_q;
  assign ADDR_OUT = addr_q;
  assign WDATA_OUT = wdata_q;
  assign WR_OUT = wr_q;
  assign MEMOP_WR_OUT = memop_wr_q;
  assign EA_OUT = ea_q;
  assign BUSY_OUT = (st_q != crf_pkg::CRF_ST_IDLE);
  assign ILLEGAL_OUT = illegal_q;
  assign IRQ_ACK_OUT = irq_ack_q;
  assign WAIT_OUT = wait_q;
  assign HALT_OUT = halt_q;

endmodule

// ### src/crf_regs.svh
/*
  Offsets, field positions, reset values and encodings of the core
  register set. Included by the package and the design file.
*/
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define CRF_PS_C 0
`define CRF_PS_Z 1
`define CRF_PS_I 2
`define CRF_PS_D 3
`define CRF_PS_B 4
`define CRF_PS_T 5
`define CRF_PS_V 6
`define CRF_PS_N 7

// ----------------------------------------------------------------
// Addresses and reset values
// ----------------------------------------------------------------
`define CRF_CPU_MODE_ADDR 16'h003b
`define CRF_SPS_BIT 2
`define CRF_PS_RESET 8'h04
`define CRF_SP_RESET 8'hff
`define CRF_PC_RESET 16'h0000
`define CRF_PAGE0_HI 8'h00
`define CRF_PAGE1_HI 8'h01

// ----------------------------------------------------------------
// Operation codes on the op port
// ----------------------------------------------------------------
`define CRF_OP_NOP 5'h00
`define CRF_OP_LOAD 5'h01
`define CRF_OP_ADC 5'h02
`define CRF_OP_SBC 5'h03
`define CRF_OP_SHIFT 5'h04
`define CRF_OP_BIT 5'h05
`define CRF_OP_PUSH_A 5'h06
`define CRF_OP_POP_A 5'h07
`define CRF_OP_PUSH_PS 5'h08
`define CRF_OP_POP_PS 5'h09
`define CRF_OP_SEC 5'h0a
`define CRF_OP_CLC 5'h0b
`define CRF_OP_SEI 5'h0c
`define CRF_OP_CLI 5'h0d
`define CRF_OP_SED 5'h0e
`define CRF_OP_CLD 5'h0f
`define CRF_OP_SET 5'h10
`define CRF_OP_CLT 5'h11
`define CRF_OP_CLV 5'h12
`define CRF_OP_CALL 5'h13
`define CRF_OP_IRQ 5'h14
`define CRF_OP_BRK 5'h15
`define CRF_OP_FAST_SET 5'h16
`define CRF_OP_SLOW 5'h17
`define CRF_OP_PRODUCT 5'h18
`define CRF_OP_QUOTIENT 5'h19
`define CRF_OP_WAIT 5'h1a
`define CRF_OP_HALT_OSC 5'h1b
`define CRF_OP_PC_LOAD 5'h1c
`define CRF_OP_PC_INC 5'h1d
`define CRF_OP_INDEX 5'h1e

`endif

// ### src/crf_pkg.sv
/*
  Types of the core register set.
  Assumes crf_regs.svh on the include path.
*/
`include "crf_regs.svh"
package crf_pkg;
  typedef logic [4:0] crf_op_t;
  typedef enum logic [2:0] {
    CRF_ST_IDLE = 3'b000,
    CRF_ST_PUSH2 = 3'b001,
    CRF_ST_PUSH3 = 3'b010,
    CRF_ST_DONE = 3'b011
  } crf_state_t;
endpackage

// ### sim/crf_core_asserts.sv
/* Concurrent checks on the crf_core ports, bound to every instance.
   Assumes crf_regs.svh on the include path. */
`timescale 1ns/1ps
`include "crf_regs.svh"
module crf_core_chk (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic OP_VALID_IN,
  input wire logic [4:0] OP_IN,
  input wire logic [7:0] MEM_DATA_IN,
  input wire logic [15:0] OPERAND_IN,
  input wire logic IDX_SEL_IN,
  input wire logic [7:0] ACC_OUT,
  input wire logic [7:0] IDX1_OUT,
  input wire logic [7:0] IDX2_OUT,
  input wire logic [7:0] SP_OUT,
  input wire logic [15:0] PC_OUT,
  input wire logic [7:0] PS_OUT,
  input wire logic [15:0] ADDR_OUT,
  input wire logic [7:0] WDATA_OUT,
  input wire logic WR_OUT,
  input wire logic [15:0] EA_OUT,
  input wire logic BUSY_OUT,
  input wire logic ILLEGAL_OUT,
  input wire logic IRQ_ACK_OUT
);
  logic taken;
  assign taken = OP_VALID_IN && !BUSY_OUT;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_break_live_low: assert property (!PS_OUT[4])
    else $error("live break flag set");
  chk_reset_irq_off: assert property ($rose(NRST_IN) |-> PS_OUT[2])
    else $error("interrupt disable clear after reset");
  chk_push_acc: assert property (taken && OP_IN == `CRF_OP_PUSH_A |=>
    WR_OUT && WDATA_OUT == $past(ACC_OUT) &&
    ADDR_OUT[7:0] == $past(SP_OUT) && SP_OUT == $past(SP_OUT) - 8'h01)
    else $error("accumulator push wrong");
  chk_pop_acc: assert property (taken && OP_IN == `CRF_OP_POP_A |=>
    SP_OUT == $past(SP_OUT) + 8'h01 && ACC_OUT == $past(MEM_DATA_IN))
    else $error("accumulator pop wrong");
  chk_irq_masked: assert property (taken && OP_IN == `CRF_OP_IRQ &&
    PS_OUT[2] |=> !IRQ_ACK_OUT && !WR_OUT)
    else $error("masked interrupt accepted");
  chk_ack_sets_i: assert property (IRQ_ACK_OUT |-> PS_OUT[2])
    else $error("interrupt accepted without disable");
  chk_break_stack: assert property (taken && OP_IN == `CRF_OP_BRK |=>
    IRQ_ACK_OUT && WR_OUT ##1 WR_OUT ##1 WR_OUT && WDATA_OUT[4])
    else $error("break entry sequence wrong");
  chk_illegal_ops: assert property (taken |=> ILLEGAL_OUT ==
    ($past(OP_IN) == `CRF_OP_FAST_SET || $past(OP_IN) == `CRF_OP_SLOW))
    else $error("rejected op flag wrong");
  chk_bit_test: assert property (taken && OP_IN == `CRF_OP_BIT |=>
    PS_OUT[7:6] == $past(MEM_DATA_IN[7:6]))
    else $error("bit test flags wrong");
  chk_index_sum: assert property (taken && OP_IN == `CRF_OP_INDEX |=>
    EA_OUT == $past(OPERAND_IN) + {8'h00,
    $past(IDX_SEL_IN) ? $past(IDX2_OUT) : $past(IDX1_OUT)})
    else $error("effective address wrong");
  chk_pc_step: assert property (taken && OP_IN == `CRF_OP_PC_INC |=>
    PC_OUT == $past(PC_OUT) + 16'h0001)
    else $error("program counter step wrong");

  cover property (taken && OP_IN == `CRF_OP_BRK);
  cover property (IRQ_ACK_OUT);
  cover property (ILLEGAL_OUT);
  cover property (taken && OP_IN == `CRF_OP_POP_A);
endmodule

bind crf_core crf_core_chk u_chk (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
  .OP_VALID_IN(OP_VALID_IN), .OP_IN(OP_IN), .MEM_DATA_IN(MEM_DATA_IN),
  .OPERAND_IN(OPERAND_IN), .IDX_SEL_IN(IDX_SEL_IN), .ACC_OUT(ACC_OUT),
  .IDX1_OUT(IDX1_OUT), .IDX2_OUT(IDX2_OUT), .SP_OUT(SP_OUT),
  .PC_OUT(PC_OUT), .PS_OUT(PS_OUT), .ADDR_OUT(ADDR_OUT),
  .WDATA_OUT(WDATA_OUT), .WR_OUT(WR_OUT), .EA_OUT(EA_OUT),
  .BUSY_OUT(BUSY_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
  .IRQ_ACK_OUT(IRQ_ACK_OUT));

// ### sim/tb_cpu_register_set_and_flags.sv
/* Bench of crf_core: a table of flag cases, then reset, stack,
   interrupt and mode cases. Assumes crf_regs.svh on the include path. */
`timescale 1ns/1ps
`include "crf_regs.svh"
module tb_cpu_register_set_and_flags;
  typedef struct {
    logic [4:0] op;
    logic [7:0] m, o, a, p, k;
  } crf_tb_row_t;
  logic clk, nrst, op_valid, idx_sel, irq_req, sfr_wr;
  logic [4:0] op;
  logic [1:0] reg_sel;
  logic [7:0] mem, sfr_data, acc, idx1, idx2, sp, ps, wdata;
  logic [15:0] opnd, sfr_addr, pc, addr, ea;
  logic wr, memop_wr, busy, illegal, irq_ack, wait_o, halt_o;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  crf_tb_row_t rows [0:23];
  logic [4:0] extra_ops [0:3] = '{`CRF_OP_FAST_SET, `CRF_OP_SLOW,
    `CRF_OP_PRODUCT, `CRF_OP_QUOTIENT};

  crf_core dut (.CLK_IN(clk), .NRST_IN(nrst), .OP_VALID_IN(op_valid),
    .OP_IN(op), .REG_SEL_IN(reg_sel), .MEM_DATA_IN(mem),
    .OPERAND_IN(opnd), .IDX_SEL_IN(idx_sel), .IRQ_REQ_IN(irq_req),
    .SFR_WR_IN(sfr_wr), .SFR_ADDR_IN(sfr_addr), .SFR_DATA_IN(sfr_data),
    .ACC_OUT(acc), .IDX1_OUT(idx1), .IDX2_OUT(idx2), .SP_OUT(sp),
    .PC_OUT(pc), .PS_OUT(ps), .ADDR_OUT(addr), .WDATA_OUT(wdata),
    .WR_OUT(wr), .MEMOP_WR_OUT(memop_wr), .EA_OUT(ea), .BUSY_OUT(busy),
    .ILLEGAL_OUT(illegal), .IRQ_ACK_OUT(irq_ack), .WAIT_OUT(wait_o),
    .HALT_OUT(halt_o));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Starts and ends at a falling edge; valid drops at the taking edge
  task automatic do_op(input logic [4:0] c, input logic [1:0] s,
                       input logic [7:0] m, input logic [15:0] o);
    op_valid = 1'b1;
    op = c;
    reg_sel = s;
    mem = m;
    opnd = o;
    @(posedge clk);
    op_valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("busy", {15'h0000, busy}, 16'h0000);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    op_valid = 1'b0;
    op = `CRF_OP_NOP;
    reg_sel = 2'h3;
    mem = 8'h00;
    opnd = 16'h0000;
    idx_sel = 1'b0;
    irq_req = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = 16'h0000;
    sfr_data = 8'h00;
    rows = '{
      '{`CRF_OP_CLI, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff},
      '{`CRF_OP_LOAD, 8'h80, 8'h00, 8'h80, 8'h80, 8'hff},
      '{`CRF_OP_LOAD, 8'h00, 8'h00, 8'h00, 8'h02, 8'hff},
      '{`CRF_OP_SEC, 8'h00, 8'h00, 8'h00, 8'h03, 8'hff},
      '{`CRF_OP_ADC, 8'h00, 8'h7f, 8'h80, 8'hc0, 8'hff},
      '{`CRF_OP_CLV, 8'h00, 8'h00, 8'h80, 8'h80, 8'hff},
      '{`CRF_OP_ADC, 8'h00, 8'h80, 8'h00, 8'h43, 8'hff},
      '{`CRF_OP_SBC, 8'h00, 8'h01, 8'hff, 8'h80, 8'hff},
      '{`CRF_OP_SHIFT, 8'h00, 8'h00, 8'hfe, 8'h81, 8'hff},
      '{`CRF_OP_BIT, 8'h40, 8'h00, 8'hfe, 8'h41, 8'hff},
      '{`CRF_OP_SED, 8'h00, 8'h00, 8'hfe, 8'h49, 8'hff},
      '{`CRF_OP_CLD, 8'h00, 8'h00, 8'hfe, 8'h41, 8'hff},
      '{`CRF_OP_SET, 8'h00, 8'h00, 8'hfe, 8'h61, 8'hff},
      '{`CRF_OP_CLT, 8'h00, 8'h00, 8'hfe, 8'h41, 8'hff},
      '{`CRF_OP_SEI, 8'h00, 8'h00, 8'hfe, 8'h45, 8'hff},
      '{`CRF_OP_CLC, 8'h00, 8'h00, 8'hfe, 8'h44, 8'hff},
      '{`CRF_OP_LOAD, 8'h09, 8'h00, 8'h09, 8'h44, 8'hff},
      '{`CRF_OP_SED, 8'h00, 8'h00, 8'h09, 8'h4c, 8'hff},
      '{`CRF_OP_ADC, 8'h00, 8'h01, 8'h10, 8'h0c, 8'h3d},
      '{`CRF_OP_SEC, 8'h00, 8'h00, 8'h10, 8'h0d, 8'h3d},
      '{`CRF_OP_SBC, 8'h00, 8'h01, 8'h09, 8'h0d, 8'h3d},
      '{`CRF_OP_CLD, 8'h00, 8'h00, 8'h09, 8'h05, 8'h3d},
      '{`CRF_OP_LOAD, 8'h00, 8'h00, 8'h00, 8'h07, 8'hbf},
      '{`CRF_OP_CLV, 8'h00, 8'h00, 8'h00, 8'h07, 8'hff}};
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    foreach (rows[i]) begin
      do_op(rows[i].op, 2'h0, rows[i].m, {8'h00, rows[i].o});
      check("acc", {8'h00, acc}, {8'h00, rows[i].a});
      check("ps", {8'h00, ps & rows[i].k},
            {8'h00, rows[i].p & rows[i].k});
    end
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check("rst", {sp, ps}, 16'hff04);
    nrst = 1'b1;
    @(negedge clk);
    do_op(`CRF_OP_LOAD, 2'h0, 8'ha5, 16'h0000);
    do_op(`CRF_OP_PUSH_A, 2'h3, 8'h00, 16'h0000);
    check("push", {wr, 7'h00, wdata}, 16'h80a5);
    check("addr", addr, 16'h00ff);
    check("sp", {8'h00, sp}, 16'h00fe);
    sfr_wr = 1'b1;
    sfr_addr = 16'h003b;
    sfr_data = 8'h04;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(negedge clk);
    do_op(`CRF_OP_PUSH_A, 2'h3, 8'h00, 16'h0000);
    check("addr", addr, 16'h01fe);
    do_op(`CRF_OP_POP_A, 2'h3, 8'h3c, 16'h0000);
    check("pop", {sp, acc}, 16'hfe3c);
    do_op(`CRF_OP_PUSH_PS, 2'h3, 8'h00, 16'h0000);
    check("psh", {8'h00, wdata}, 16'h0014);
    do_op(`CRF_OP_POP_PS, 2'h3, 8'hff, 16'h0000);
    check("plp", {sp, ps}, 16'hfeef);
    do_op(`CRF_OP_POP_PS, 2'h3, 8'h04, 16'h0000);
    do_op(`CRF_OP_LOAD, 2'h1, 8'h05, 16'h0000);
    do_op(`CRF_OP_LOAD, 2'h2, 8'hfa, 16'h0000);
    check("idx", {idx1, idx2}, 16'h05fa);
    do_op(`CRF_OP_INDEX, 2'h3, 8'h00, 16'h1000);
    check("ea", ea, 16'h1005);
    idx_sel = 1'b1;
    do_op(`CRF_OP_INDEX, 2'h3, 8'h00, 16'h10ff);
    check("ea", ea, 16'h11f9);
    do_op(`CRF_OP_SET, 2'h3, 8'h00, 16'h0000);
    do_op(`CRF_OP_ADC, 2'h3, 8'h10, 16'h0022);
    check("mop", {memop_wr, 7'h00, wdata}, 16'h8032);
    check("madr", addr, 16'h0005);
    check("macc", {8'h00, acc}, 16'h003c);
    do_op(`CRF_OP_CLT, 2'h3, 8'h00, 16'h0000);
    do_op(`CRF_OP_PC_LOAD, 2'h3, 8'h00, 16'h12ff);
    do_op(`CRF_OP_PC_INC, 2'h3, 8'h00, 16'h0000);
    check("pc", pc, 16'h1300);
    do_op(`CRF_OP_BRK, 2'h3, 8'h00, 16'h0000);
    check("brk1", {irq_ack, wr, busy, ps[2], 4'h0, wdata}, 16'hf013);
    check("brka", addr, 16'h01ff);
    @(negedge clk);
    check("brk2", {wr, 7'h00, wdata}, 16'h8000);
    @(negedge clk);
    check("brk3", {14'h0000, wr, wdata[4]}, 16'h0003);
    wait_idle();
    irq_req = 1'b1;
    do_op(`CRF_OP_IRQ, 2'h3, 8'h00, 16'h0000);
    check("mask", {14'h0000, irq_ack, wr}, 16'h0000);
    do_op(`CRF_OP_CLI, 2'h3, 8'h00, 16'h0000);
    do_op(`CRF_OP_IRQ, 2'h3, 8'h00, 16'h0000);
    check("irq", {14'h0000, irq_ack, ps[2]}, 16'h0003);
    irq_req = 1'b0;
    repeat (2) @(negedge clk);
    check("irqs", {14'h0000, wr, wdata[4]}, 16'h0002);
    wait_idle();
    do_op(`CRF_OP_CALL, 2'h3, 8'h00, 16'h0000);
    check("call", {wr, 7'h00, wdata}, 16'h8013);
    wait_idle();
    check("csp", {8'h00, sp}, 16'h00f7);
    foreach (extra_ops[i]) begin
      do_op(extra_ops[i], 2'h3, 8'h00, 16'h0000);
      check("ill", {15'h0000, illegal}, 16'(i < 2));
    end
    for (int i = 0; i < 2; i++) begin
      do_op(i ? `CRF_OP_HALT_OSC : `CRF_OP_WAIT, 2'h3, 8'h00, 16'h0000);
      check("slp", {14'h0000, halt_o, wait_o}, 16'(i + 1));
      irq_req = 1'b1;
      repeat (2) @(negedge clk);
      irq_req = 1'b0;
      check("wake", {14'h0000, halt_o, wait_o}, 16'h0000);
    end
    tally_and_finish();
  end
endmodule
